// ### logic/fbep_defines.svh
// Constants for the flash block erase and protect logic.
`ifndef FBEP_DEFINES_SVH
`define FBEP_DEFINES_SVH
`define FBEP_ARRAY_BYTES   32768
`define FBEP_UNIT_BYTES    1024
`define FBEP_REGION_BYTES  2048
`define FBEP_WORD_BYTES    4
`define FBEP_ERASED_WORD   32'hffffffff
`define FBEP_PROT_OPEN     2'h0
`define FBEP_PROT_RDONLY   2'h1
`define FBEP_PROT_XONLY    2'h3
`endif

// ### logic/fbep_pkg.sv
// Types for the flash block erase and protect logic.
package fbep_pkg;
  // Region protection setting, Gray ordered.
  typedef enum logic [1:0] {
    FBEP_OPEN   = 2'h0,
    FBEP_RDONLY = 2'h1,
    FBEP_XONLY  = 2'h3
  } fbep_prot_t;

  // Kind of a read request.
  typedef enum logic [1:0] {
    FBEP_RD_FETCH = 2'h0,
    FBEP_RD_DATA  = 2'h1,
    FBEP_RD_DEBUG = 2'h3
  } fbep_src_t;

  // Modify engine states, Gray along idle, erase, done.
  typedef enum logic [1:0] {
    FBEP_IDLE  = 2'h0,
    FBEP_ERASE = 2'h1,
    FBEP_DONE  = 2'h3
  } fbep_state_t;

  // Read request carrier.
  typedef struct packed {
    logic      valid;
    fbep_src_t src;
    logic [12:0] addr;
  } fbep_rd_req_t;

  // Modify request carrier: program a word or erase a unit.
  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [12:0] addr;
    logic [31:0] data;
  } fbep_wr_req_t;
endpackage

// ### logic/fbep_prot_check.sv
// Region protection table and per-access permission check.
`timescale 1ns/1ns
`default_nettype none
`include "fbep_defines.svh"
module fbep_prot_check
  import fbep_pkg::*;
#(
  parameter int REGIONS = 16
) (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Setting write port.
  input  wire logic                       set_en,
  input  wire logic [$clog2(REGIONS)-1:0] set_idx,
  input  wire logic [1:0]                 set_val,
  // Queries.
  input  wire logic [$clog2(REGIONS)-1:0] rd_idx,
  input  wire fbep_src_t                  rd_src,
  input  wire logic [$clog2(REGIONS)-1:0] wr_idx,
  output logic                            rd_ok,
  output logic                            wr_ok
);
  logic [1:0] prot_q [REGIONS];

  // The index ports match the entry count exactly only for a power of two above one.
  if (REGIONS < 2 || (REGIONS & (REGIONS - 1)) != 0) begin : g_bad_regions
    $error("fbep_prot_check: unsupported region count");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REGIONS; i++) prot_q[i] <= `FBEP_PROT_OPEN;
    end else if (set_en) begin
      prot_q[set_idx] <= set_val;
    end
  end

  assign rd_ok = (prot_q[rd_idx] != `FBEP_PROT_XONLY) ||
                 (rd_src == FBEP_RD_FETCH);
  assign wr_ok = (prot_q[wr_idx] == `FBEP_PROT_OPEN);
endmodule // fbep_prot_check
`default_nettype wire

// ### logic/fbep_top.sv
// Flash array access, block erase and region protection.
//
// How it works
// - Array holds 32 kilobytes of words reached by fetch and data paths.
// - Erase works on one 1 KB unit and leaves others untouched.
// - An allowed erase leaves every bit of the unit at one.
// - Two adjacent units form one 2 KB protection region.
// - Each region can be open, read-only or execute-only.
// - Read-only regions refuse erase and program.
// - Execute-only regions refuse erase and program.
// - Execute-only regions answer only instruction fetches.
// - Allowed reads answer one cycle later, no wait states.
`timescale 1ns/1ns
`default_nettype none
`include "fbep_defines.svh"
module fbep_top
  import fbep_pkg::*;
#(
  parameter int ARRAY_BYTES  = `FBEP_ARRAY_BYTES,
  parameter int UNIT_BYTES   = `FBEP_UNIT_BYTES,
  parameter int REGION_BYTES = `FBEP_REGION_BYTES
) (
  // Clock and reset.
  input  wire logic   MCLK,
  input  wire logic   RST_N,
  // Read port, word address.
  input  wire fbep_rd_req_t RD_REQ,
  output logic [31:0] RD_DATA,
  output logic        RD_VALID,
  output logic        RD_ERR,
  // Program and erase port.
  input  wire fbep_wr_req_t WR_REQ,
  output logic        WR_BUSY,
  output logic        WR_DONE,
  output logic        WR_ERR,
  // Protection setting port.
  input  wire logic       PROT_SET,
  input  wire logic [3:0] PROT_IDX,
  input  wire logic [1:0] PROT_VAL
);
  localparam int WORDS   = ARRAY_BYTES / `FBEP_WORD_BYTES;
  localparam int UWORDS  = UNIT_BYTES / `FBEP_WORD_BYTES;
  localparam int REGIONS = ARRAY_BYTES / REGION_BYTES;
  localparam int AW      = $clog2(WORDS);
  localparam int UW      = $clog2(UWORDS);
  localparam int RW      = $clog2(REGIONS);

  // Refuse geometries that the address slices and 4-bit region port miss.
  localparam bit GEOM_OK = (WORDS == 8192) &&
                           (REGION_BYTES == 2 * UNIT_BYTES) &&
                           (REGIONS == 16);
  if (!GEOM_OK) begin : g_bad_geometry
    $error("fbep_top: unsupported geometry");
  end

  // Region index of a word address.
  function automatic logic [RW-1:0] region_of(input logic [AW-1:0] a);
    return a[AW-1 -: RW];
  endfunction

  logic [31:0] mem [WORDS];

  logic          rd_ok;
  logic          wr_ok;
  fbep_state_t   state_q;
  logic [AW-UW-1:0] unit_q;
  logic [UW-1:0] ecnt_q;
  logic          busy_q;
  logic          done_q;
  logic          werr_q;
  logic          rvalid_q;
  logic          rerr_q;
  logic [31:0]   rdata_q;

  fbep_prot_check #(.REGIONS(REGIONS)) u_prot (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .set_en (PROT_SET),
    .set_idx(PROT_IDX),
    .set_val(PROT_VAL),
    .rd_idx (region_of(RD_REQ.addr)),
    .rd_src (RD_REQ.src),
    .wr_idx (region_of(WR_REQ.addr)),
    .rd_ok  (rd_ok),
    .wr_ok  (wr_ok)
  );

  wire start_w = WR_REQ.valid && (state_q == FBEP_IDLE);
  wire take_w  = start_w && wr_ok;
  wire last_w  = (ecnt_q == UW'(UWORDS - 1));
  wire [AW-1:0] eaddr_w = {unit_q, ecnt_q};

  // single cycle read; refused or idle reads show zero.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= (RD_REQ.valid && rd_ok) ? mem[RD_REQ.addr] : 32'h00000000;
    end
  end

  // Read handshake flags.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rerr_q   <= 1'b0;
    end else begin
      rvalid_q <= RD_REQ.valid && rd_ok;
      rerr_q   <= RD_REQ.valid && !rd_ok;
    end
  end

  // array writes; erase walks one unit.
  always_ff @(posedge MCLK) begin
    if (state_q == FBEP_ERASE)
      mem[eaddr_w] <= `FBEP_ERASED_WORD;
    else if (take_w && !WR_REQ.erase)
      mem[WR_REQ.addr] <= mem[WR_REQ.addr] & WR_REQ.data;
  end

  // Modify engine.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= FBEP_IDLE;
      unit_q  <= '0;
      ecnt_q  <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      werr_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      werr_q <= 1'b0;
      case (state_q)
        FBEP_IDLE: begin
          werr_q <= start_w && !wr_ok;
          if (take_w && WR_REQ.erase) begin
            state_q <= FBEP_ERASE;
            unit_q  <= WR_REQ.addr[AW-1:UW];
            ecnt_q  <= '0;
            busy_q  <= 1'b1;
          end else begin
            done_q <= take_w;
          end
        end
        FBEP_ERASE: begin
          ecnt_q <= ecnt_q + 1'b1;
          if (last_w) begin
            state_q <= FBEP_DONE;
          end
        end
        FBEP_DONE: begin
          state_q <= FBEP_IDLE;
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
        end
        default: begin
          state_q <= FBEP_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  assign RD_DATA  = rdata_q;
  assign RD_VALID = rvalid_q;
  assign RD_ERR   = rerr_q;
  assign WR_BUSY  = busy_q;
  assign WR_DONE  = done_q;
  assign WR_ERR   = werr_q;

  property p_rd_one;
    @(posedge MCLK) disable iff (!RST_N)
      (RD_REQ.valid && rd_ok) |=> RD_VALID && !RD_ERR;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read late");

  property p_xonly;
    @(posedge MCLK) disable iff (!RST_N)
      (RD_REQ.valid && RD_REQ.src != FBEP_RD_FETCH && !rd_ok)
        |=> RD_ERR && !RD_VALID && RD_DATA == 32'h00000000;
  endproperty
  a_xonly: assert property (p_xonly) else $error("xonly leak");

  property p_werr;
    @(posedge MCLK) disable iff (!RST_N)
      (start_w && !wr_ok) |=> WR_ERR && !WR_BUSY && !WR_DONE;
  endproperty
  a_werr: assert property (p_werr) else $error("no write error");

  property p_keep;
    @(posedge MCLK) disable iff (!RST_N)
      (start_w && !wr_ok && !WR_REQ.erase)
        |=> mem[$past(WR_REQ.addr)] == $past(mem[WR_REQ.addr]);
  endproperty
  a_keep: assert property (p_keep) else $error("protected changed");

  property p_noerase;
    @(posedge MCLK) disable iff (!RST_N)
      (start_w && !wr_ok) |=> state_q == FBEP_IDLE;
  endproperty
  a_noerase: assert property (p_noerase) else $error("erase ran");

  property p_elen;
    @(posedge MCLK) disable iff (!RST_N)
      (take_w && WR_REQ.erase) |=> WR_BUSY ##256 state_q == FBEP_DONE;
  endproperty
  a_elen: assert property (p_elen) else $error("erase length");

  property p_ones;
    @(posedge MCLK) disable iff (!RST_N)
      (state_q == FBEP_ERASE) |=> mem[$past(eaddr_w)] == `FBEP_ERASED_WORD;
  endproperty
  a_ones: assert property (p_ones) else $error("not erased");

  property p_prog;
    @(posedge MCLK) disable iff (!RST_N)
      (take_w && !WR_REQ.erase) |=> WR_DONE && !WR_BUSY;
  endproperty
  a_prog: assert property (p_prog) else $error("program done");
endmodule // fbep_top
`default_nettype wire

// ### tb/fbep_host_model.sv
// Requester model: fetch and data paths and debugger.
`timescale 1ns/1ns
`default_nettype none
module fbep_host_model
  import fbep_pkg::*;
(
  // Clock and engine state.
  input  wire logic        clk,
  input  wire logic        busy,
  // Requests towards the flash.
  output var fbep_rd_req_t rd_req,
  output var fbep_wr_req_t wr_req
);
  // Both request carriers start idle.
  initial begin
    rd_req = '0;
    wr_req = '0;
  end

  // One read; the edge that sees valid takes it.
  task automatic rd(input fbep_src_t s, input logic [12:0] a);
    @(posedge clk);
    rd_req <= '{1'b1, s, a};
    @(posedge clk);
    rd_req <= '{1'b0, s, ~a};
  endtask

  // One modify request, raised only while the engine is free.
  task automatic wr(input logic e, input logic [12:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    while (busy) @(posedge clk);
    wr_req <= '{1'b1, e, a, d};
    @(posedge clk);
    wr_req <= '{1'b0, e, ~a, ~d};
  endtask
endmodule // fbep_host_model
`default_nettype wire

// ### tb/flash_block_erase_protect_bench.sv
// Self-checking bench for the flash erase and protect logic.
`timescale 1ns/1ns
`default_nettype none
`include "fbep_defines.svh"
module flash_block_erase_protect_bench
  import fbep_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  logic         prot_set = 1'b0;
  logic [3:0]   prot_idx = 4'h0;
  logic [1:0]   prot_val = 2'h0;
  fbep_rd_req_t rd_req;
  fbep_wr_req_t wr_req;
  logic [31:0]  rd_data;
  logic         rd_valid, rd_err, wr_busy, wr_done, wr_err;
  int           miscompares = 0;
  int           check_count = 0;
  localparam logic [33:0] REFUSED = {2'b01, 32'h0};

  // Clock of 4 ns period.
  always #2 mclk = ~mclk;

  fbep_top u_fbep_top (.MCLK(mclk), .RST_N(rst_n), .RD_REQ(rd_req),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_ERR(rd_err),
    .WR_REQ(wr_req), .WR_BUSY(wr_busy), .WR_DONE(wr_done),
    .WR_ERR(wr_err), .PROT_SET(prot_set), .PROT_IDX(prot_idx),
    .PROT_VAL(prot_val));
  fbep_host_model u_fbep_host_model (.clk(mclk), .busy(wr_busy),
    .rd_req(rd_req), .wr_req(wr_req));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Read one word and judge the answer in the following cycle.
  task automatic rd_exp(input fbep_src_t s, input logic [12:0] a,
                        input logic [33:0] exp);
    u_fbep_host_model.rd(s, a);
    #1;
    chk({rd_valid, rd_err, rd_data}, exp);
  endtask

  // Program or erase; an accepted erase must finish on cycle 258.
  task automatic wr_exp(input logic e, input logic [12:0] a,
                        input logic [31:0] d, input logic ok);
    int n;
    u_fbep_host_model.wr(e, a, d);
    #1;
    n = 1;
    if (ok && e) begin
      chk({33'h0, wr_busy}, 34'h1);
      while (!wr_done && n < 400) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk(34'(n), 34'd258);
      chk({33'h0, wr_busy}, 34'h0);
    end
    chk({32'h0, wr_done, wr_err}, {32'h0, ok, !ok});
    repeat (2) @(posedge mclk);
  endtask

  task automatic prot(input logic [3:0] i, input logic [1:0] v);
    @(posedge mclk);
    prot_set <= 1'b1;
    prot_idx <= i;
    prot_val <= v;
    @(posedge mclk);
    prot_set <= 1'b0;
  endtask

  task automatic t_erase;
    wr_exp(1'b1, 13'h0, 32'h0, 1'b1);
    rd_exp(FBEP_RD_FETCH, 13'h0, {2'b10, 32'hffffffff});
    rd_exp(FBEP_RD_DATA, 13'hff, {2'b10, 32'hffffffff});
    wr_exp(1'b0, 13'h0, 32'h12345678, 1'b1);
    wr_exp(1'b1, 13'h100, 32'h0, 1'b1);
    wr_exp(1'b0, 13'h0, 32'hff00ffff, 1'b1);
    rd_exp(FBEP_RD_DATA, 13'h0, {2'b10, 32'h12005678});
    wr_exp(1'b1, 13'h1fff, 32'h0, 1'b1);
    rd_exp(FBEP_RD_DEBUG, 13'h1fff, {2'b10, 32'hffffffff});
  endtask

  task automatic t_rdonly;
    prot(4'h0, `FBEP_PROT_RDONLY);
    wr_exp(1'b1, 13'h100, 32'h0, 1'b0);
    wr_exp(1'b0, 13'h0, 32'h0, 1'b0);
    wr_exp(1'b1, 13'h0, 32'h0, 1'b0);
    rd_exp(FBEP_RD_DEBUG, 13'h0, {2'b10, 32'h12005678});
    wr_exp(1'b1, 13'h200, 32'h0, 1'b1);
  endtask

  task automatic t_xonly;
    prot(4'h0, `FBEP_PROT_XONLY);
    rd_exp(FBEP_RD_DATA, 13'h0, REFUSED);
    rd_exp(FBEP_RD_DEBUG, 13'h1ff, REFUSED);
    rd_exp(FBEP_RD_FETCH, 13'h0, {2'b10, 32'h12005678});
    wr_exp(1'b0, 13'h0, 32'h0, 1'b0);
    wr_exp(1'b1, 13'h100, 32'h0, 1'b0);
    prot(4'h0, `FBEP_PROT_OPEN);
    rd_exp(FBEP_RD_DATA, 13'h0, {2'b10, 32'h12005678});
    wr_exp(1'b0, 13'h0, 32'h0, 1'b1);
    rd_exp(FBEP_RD_DEBUG, 13'h0, {2'b10, 32'h0});
  endtask

  // A reset in mid-run clears every output and reopens every region.
  task automatic t_reset;
    prot(4'h0, `FBEP_PROT_XONLY);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk({28'h0, rd_valid, rd_err, wr_busy, wr_done, wr_err, |rd_data},
        34'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_exp(FBEP_RD_DATA, 13'h0, {2'b10, 32'h0});
  endtask

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_erase;
    t_rdonly;
    t_xonly;
    t_reset;
    stop_test;
  end

  // Watchdog well beyond the roughly 1100 cycles the run needs.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test;
  end
endmodule // flash_block_erase_protect_bench
`default_nettype wire
